// *** tb/vaac_enc_model.sv ***
`timescale 1ns/100ps
module vaac_enc_model import vaac_pkg::*; (
   input  wire logic      clk_i,          // bench clock
   input  wire logic      frame_ready_i,  // core takes frames
   input  wire logic      lags_ready_i,   // core takes lags
   output vaac_frame_type frame_o,        // frame data
   output logic           frame_valid_o,  // frame offered
   output vaac_lags_type  lags_o,         // pitch lags
   output logic           lags_valid_o    // lags offered
);
   initial
   begin
      frame_o = '0;
      frame_valid_o = 1'b0;
      lags_o = '0;
      lags_valid_o = 1'b0;
   end
   // raised only once complete, held until taken; released data shows the inverse
   task automatic send_frame(input vaac_frame_type f, input int dly, output bit ok);
      repeat (dly + 1) @(negedge clk_i);
      frame_o = f;
      frame_valid_o = 1'b1;
      ok = 0;
      for (int n = 0; n < 300 && !ok; n++)
      begin
         if (frame_ready_i === 1'b1)
            ok = 1;
         else
            @(negedge clk_i);
      end
      @(negedge clk_i);
      frame_valid_o = 1'b0;
      frame_o = ~f;
   endtask
   task automatic send_lags(input vaac_lags_type l, input int dly, output bit ok);
      repeat (dly + 1) @(negedge clk_i);
      lags_o = l;
      lags_valid_o = 1'b1;
      ok = 0;
      for (int n = 0; n < 300 && !ok; n++)
      begin
         if (lags_ready_i === 1'b1)
            ok = 1;
         else
            @(negedge clk_i);
      end
      @(negedge clk_i);
      lags_valid_o = 1'b0;
      lags_o = ~l;
   endtask
endmodule // vaac_enc_model

// *** tb/voice_activity_arith_core_bench.sv ***
`timescale 1ns/100ps
module voice_activity_arith_core_bench import vaac_pkg::*;;
   localparam int CF = 12;
   localparam int RCT[5][4] = '{'{0, 125, 125, 125}, '{20, 125, 125, 125},
      '{-125, 90, 125, 125}, '{-50, 90, 125, 125}, '{125, -64, 125, 125}};
   logic            ref_clk_i = 1'b0;
   logic            arst_n_i = 1'b0;
   logic            fv, fr_rdy, lv, lg_rdy, rv, ptch;
   vaac_frame_type  fr;
   vaac_lags_type   lg;
   vaac_result_type res;
   int              failures, check_count, lag0_m, oldcnt_m;
   int              seed = 16356;
   bit              ptch_m;
   vaac_pf_type     thv;

   always #2 ref_clk_i = ~ref_clk_i;

   vaac_core #(.COEF_FRAC(CF)) DUT (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
      .frame_valid_i(fv), .frame_i(fr), .frame_ready_o(fr_rdy), .lags_valid_i(lv),
      .lags_i(lg), .lags_ready_o(lg_rdy), .result_o(res), .result_valid_o(rv), .ptch_o(ptch));
   vaac_enc_model enc (.clk_i(ref_clk_i), .frame_ready_i(fr_rdy), .lags_ready_i(lg_rdy),
      .frame_o(fr), .frame_valid_o(fv), .lags_o(lg), .lags_valid_o(lv));

   task check(string nm, logic [63:0] seen, logic [63:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function vaac_pf_type pf(longint v);
      vaac_pf_type r;
      int          p;
      r = '0;
      p = -1;
      for (int b = 0; b < 48; b++)
         if (v[b])
            p = b;
      if (p >= 0)
      begin
         r.e = 16'(p + 1);
         r.m = 16'(p >= 14 ? v >>> (p - 14) : v << (14 - p));
      end
      return r;
   endfunction
   function bit gt(vaac_pf_type a, vaac_pf_type b);
      return a.e > b.e || (a.e == b.e && a.m > b.m);
   endfunction
   task final_report;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task do_reset;
      @(negedge ref_clk_i);
      arst_n_i = 1'b0;
      repeat (5) @(negedge ref_clk_i);
      check("rst_flags", {fr_rdy, lg_rdy, rv, ptch}, 4'h9);
      check("rst_result", |res, 1'b0);
      arst_n_i = 1'b1;
      thv = '{e: 16'h0014, m: 16'h69CB};
      ptch_m = 1;
      lag0_m = 18;
      oldcnt_m = 0;
   endtask
   task run_frame(int k);
      vaac_frame_type f;
      vaac_lags_type  l;
      vaac_pf_type    pv, ie, tu;
      longint         r, s, im4, err;
      int             a1, a2, n, d1, d2, cnt, u[4];
      bit             tone, vv, ok1, ok2, bad, perr;
      s = 0;
      for (int i = 0; i < 9; i++)
      begin
         f.acf[i] = $random(seed) & 32'h000FFFFF;
         f.coef[i] = 16'($random(seed) % 2048);
      end
      f.acf[0] = $random(seed) & (k[0] ? 32'h0001FFFF : 32'h00FFFFFF);
      f.coef[0] = 16'h1000;
      for (int i = 0; i < 4; i++)
      begin
         u[i] = k < 5 ? RCT[k][i] : $random(seed) % 128;
         f.rc[i] = 16'(u[i] * 256);
      end
      l.lag1 = (k % 8 == 7) ? 8'(40 + $random(seed) % 30) : 8'(lag0_m + $random(seed) % 3);
      l.lag2 = 8'(l.lag1 + $random(seed) % 3);
      for (int i = 0; i < 9; i++)
      begin
         r = 0;
         for (int j = 0; j < 9 - i; j++)
            r += longint'($signed(f.coef[j])) * $signed(f.coef[j + i]);
         s += (i == 0 ? 1 : 2) * r * longint'(f.acf[i]);
      end
      pv = pf(s < 0 ? 0 : s >>> (2 * CF));
      ie = pf(longint'(f.acf[0]));
      tu = thv;
      vv = gt(pv, tu);
      if (gt('{e: 16'h0011, m: 16'h7EF4}, ie))
         thv = '{e: 16'h0013, m: 16'h54A3};
      a1 = u[0] * 256 + u[0] * u[1] * 2;
      a2 = u[1] * 256;
      im4 = longint'(a2) * 131072 - longint'(a1) * a1;
      err = 32767;
      for (int i = 0; i < 4; i++)
         err = err * (32768 - u[i] * u[i] * 2) >>> 15;
      perr = im4 >= 0 && !(a1 < 0 && im4 * 10000 < 973 * longint'(a1) * a1);
      tone = perr && err < 1465;
      enc.send_frame(f, $random(seed) & 3, ok1);
      fork
         enc.send_lags(l, $random(seed) & 63, ok2);
         begin
            n = 1;
            bad = 0;
            while (n < 60 && rv !== 1'b1)
            begin
               bad |= fr_rdy !== 1'b0 || ptch !== ptch_m;
               @(negedge ref_clk_i);
               n++;
            end
            check("latency", n, perr ? 51 : 47);
            check("lags_ready", lg_rdy, 1'b1);
            check("hold", bad, 1'b0);
         end
      join
      if (!(ok1 && ok2))
      begin
         failures++;
         final_report;
      end
      check("pvad", res.pvad, pv);
      check("thvad", res.thvad, tu);
      check("energy", res.input_energy, ie);
      check("vvad", res.vvad, vv);
      check("tone", res.tone, tone);
      check("ptch_used", res.ptch_used, ptch_m);
      d1 = int'(l.lag1) - lag0_m;
      d2 = int'(l.lag2) - int'(l.lag1);
      cnt = (d1 < 2 && d1 > -2) + (d2 < 2 && d2 > -2);
      ptch_m = cnt + oldcnt_m >= 4;
      oldcnt_m = cnt;
      lag0_m = l.lag2;
      check("ptch", ptch, ptch_m);
      check("frame_ready", {fr_rdy, lg_rdy}, 2'h2);
   endtask

   initial
   begin
      failures = 0;
      check_count = 0;
      check("margin", MARGIN_PF, {16'h001B, 16'h421F});
      do_reset;
      for (int k = 0; k < 40; k++)
         run_frame(k);
      do_reset;
      for (int k = 0; k < 8; k++)
         run_frame(k);
      final_report;
   end
endmodule // voice_activity_arith_core_bench

// *** verilog/vaac_core.sv ***
`timescale 1ns/100ps
module vaac_core import vaac_pkg::*; #(
   parameter int COEF_FRAC = 12                    // fraction bits of filter coefficients
) (
   input  wire logic            ref_clk_i,         // 250 MHz clock
   input  wire logic            arst_n_i,          // async reset, active low
   input  wire logic            frame_valid_i,     // frame inputs complete
   input  wire vaac_frame_type  frame_i,           // autocorrelation, coefficients, reflections
   output logic                 frame_ready_o,     // frame may be taken
   input  wire logic            lags_valid_i,      // both pitch lags present
   input  wire vaac_lags_type   lags_i,            // current pitch lags
   output logic                 lags_ready_o,      // lags may be taken
   output vaac_result_type      result_o,          // decision of the frame
   output logic                 result_valid_o,    // one-cycle result strobe
   output logic                 ptch_o             // current periodic flag
);
   if (COEF_FRAC < 1 || COEF_FRAC > 15)
   begin : g_bad_frac
      $error("COEF_FRAC out of range");
   end

   vaac_regs_type      s_q;
   vaac_regs_type      s_d;
   logic [3:0]         kp;
   logic signed [31:0] prod;
   logic signed [39:0] rsum;
   logic signed [72:0] term;
   logic signed [71:0] pshift;
   logic [47:0]        pint;
   vaac_pf_type        pvad_pf;
   vaac_pf_type        eacf_pf;
   logic               vvad;
   logic signed [33:0] a1;
   logic signed [18:0] a1q;
   logic signed [39:0] a1sq;
   logic signed [39:0] im4;
   logic signed [63:0] lhs;
   logic signed [63:0] rhs;
   logic               im_neg;
   logic signed [31:0] rcsq;
   logic [16:0]        fac;
   logic [32:0]        errp;
   logic [15:0]        err_nx;
   logic [LAG_W-1:0]   d1;
   logic [LAG_W-1:0]   d2;
   logic [2:0]         cnt;

   assign frame_ready_o  = (s_q.st == ST_IDLE);
   assign lags_ready_o   = (s_q.st == ST_LAGS);
   assign result_o       = s_q.res;
   assign result_valid_o = s_q.dvalid;
   assign ptch_o         = s_q.ptch;

   always_comb
   begin
      s_d    = s_q;
      s_d.dvalid = 1'b0;
      kp     = 4'(s_q.k + s_q.i);
      prod   = $signed(s_q.fr.coef[s_q.k]) * $signed(s_q.fr.coef[kp]);
      rsum   = s_q.racc + 40'(prod);
      term   = rsum * $signed({1'b0, s_q.fr.acf[s_q.i]});
      pshift = s_q.pacc >>> (2 * COEF_FRAC);
      pint   = pshift[71] ? 48'h0 : pshift[47:0];
      pvad_pf = vaac_norm(pint);
      eacf_pf = vaac_norm({16'h0000, s_q.fr.acf[0]});
      vvad   = vaac_gt(pvad_pf, s_q.thvad);
      a1     = ($signed({{2{s_q.fr.rc[0][15]}}, s_q.fr.rc[0]}) <<< Q15_SH)
             + 34'($signed(s_q.fr.rc[0]) * $signed(s_q.fr.rc[1]));
      a1q    = 19'(a1 >>> Q15_SH);
      a1sq   = 40'(a1q) * 40'(a1q);
      im4    = ($signed({{24{s_q.fr.rc[1][15]}}, s_q.fr.rc[1]}) <<< 17) - a1sq;
      im_neg = im4 < 0;
      lhs    = 64'(im4) * $signed(FREQTH_DEN);
      rhs    = 64'(a1sq) * $signed(FREQTH_NUM);
      rcsq   = $signed(s_q.fr.rc[s_q.n]) * $signed(s_q.fr.rc[s_q.n]);
      fac    = Q15_ONE - 17'(rcsq >>> Q15_SH);
      errp   = 33'(s_q.err) * 33'(fac);
      err_nx = 16'(errp >> Q15_SH);
      d1     = (lags_i.lag1 > s_q.lag0) ? lags_i.lag1 - s_q.lag0 : s_q.lag0 - lags_i.lag1;
      d2     = (lags_i.lag2 > lags_i.lag1) ? lags_i.lag2 - lags_i.lag1
                                           : lags_i.lag1 - lags_i.lag2;
      cnt    = 3'(d1 < LTHRESH) + 3'(d2 < LTHRESH);
      unique case (s_q.st)
         ST_IDLE:
         begin
            if (frame_valid_i)
            begin
               s_d.fr      = frame_i;
               s_d.i       = 4'h0;
               s_d.k       = 4'h0;
               s_d.racc    = '0;
               s_d.pacc    = '0;
               s_d.started = 1'b1;
               s_d.st      = ST_RACC;
            end
         end
         ST_RACC:
         begin
            s_d.k    = s_q.k + 4'h1;
            s_d.racc = rsum;
            if (s_q.k == 4'(NACF - 1) - s_q.i)
            begin
               s_d.k    = 4'h0;
               s_d.i    = s_q.i + 4'h1;
               s_d.racc = '0;
               s_d.pacc = s_q.pacc + ((s_q.i == 4'h0) ? 72'(term) : 72'(term <<< 1));
               if (s_q.i == 4'(NACF - 1))
                  s_d.st = ST_TONE;
            end
         end
         ST_TONE:
         begin
            s_d.res.pvad         = pvad_pf;
            s_d.res.thvad        = s_q.thvad;
            s_d.res.input_energy = eacf_pf;
            s_d.res.vvad         = vvad;
            s_d.res.ptch_used    = s_q.ptch;
            s_d.res.tone         = 1'b0;
            if (vaac_gt(PTH_PF, eacf_pf))
               s_d.thvad = PLEV_PF;
            s_d.err = ERR_ONE;
            s_d.n   = 2'h0;
            if (im_neg)
            begin
               s_d.dvalid = 1'b1;
               s_d.st     = ST_LAGS;
            end
            else if (a1 >= 0)
               s_d.st = ST_PERR;
            else if (lhs < rhs)
            begin
               s_d.dvalid = 1'b1;
               s_d.st     = ST_LAGS;
            end
            else
               s_d.st = ST_PERR;
         end
         ST_PERR:
         begin
            s_d.err = err_nx;
            s_d.n   = s_q.n + 2'h1;
            if (s_q.n == 2'(NRC - 1))
            begin
               s_d.res.tone = err_nx < PREDTH_Q15;
               s_d.dvalid   = 1'b1;
               s_d.st       = ST_LAGS;
            end
         end
         ST_LAGS:
         begin
            if (lags_valid_i)
            begin
               s_d.ptch   = (cnt + s_q.oldcnt) >= NTHRESH;
               s_d.oldcnt = cnt;
               s_d.lag0   = lags_i.lag2;
               s_d.st     = ST_IDLE;
            end
         end
         default:
            s_d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s_q        <= '0;
         s_q.st     <= ST_IDLE;
         s_q.ptch   <= PTCH_INIT;
         s_q.lag0   <= LAG0_INIT;
         s_q.thvad  <= THVAD_INIT;
         s_q.oldcnt <= 3'h0;
      end
      else
         s_q <= s_d;
   end

   init_state_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      !s_q.started |-> (s_q.thvad == THVAD_INIT && s_q.ptch && s_q.lag0 == LAG0_INIT))
      else $error("state not at starting values before first frame");

   start_gate_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (s_q.st == ST_RACC && $past(s_q.st) == ST_IDLE) |-> $past(frame_valid_i))
      else $error("computation began without a complete frame");

   prev_ptch_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      s_q.dvalid |-> s_q.res.ptch_used == s_q.ptch)
      else $error("decision used a periodic flag other than the previous one");

   lag_order_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      $changed(s_q.ptch) |-> ($past(s_q.st) == ST_LAGS && $past(lags_valid_i)))
      else $error("periodic flag changed outside the lag update");

   mant_norm_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (s_q.dvalid && s_q.res.pvad.e != 16'h0000) |-> s_q.res.pvad.m[15:14] == 2'b01)
      else $error("filtered energy mantissa not normalised");

   raw_decide_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      s_q.dvalid |-> s_q.res.vvad == ({s_q.res.pvad.e, s_q.res.pvad.m}
                                      > {s_q.res.thvad.e, s_q.res.thvad.m}))
      else $error("raw decision disagrees with energy against threshold");

   im_neg_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (s_q.st == ST_TONE && im_neg) |=> (s_q.dvalid && !s_q.res.tone))
      else $error("real poles not rejected as a tone");

   pred_err_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (s_q.dvalid && s_q.res.tone) |-> s_q.err < PREDTH_Q15)
      else $error("tone flagged with prediction error above threshold");

   perr_len_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (s_q.st == ST_TONE && !im_neg && a1 >= 0) |=> (s_q.st == ST_PERR) [*4] ##1 s_q.dvalid)
      else $error("high-frequency pole did not go to the prediction-error test");

   lag_take_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (s_q.st == ST_LAGS && lags_valid_i) |=> (s_q.st == ST_IDLE && s_q.lag0 == $past(lags_i.lag2)))
      else $error("pitch lags not taken in the lag update");

   thr_floor_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
      (s_q.st == ST_TONE && ({PTH_PF.e, PTH_PF.m} > {eacf_pf.e, eacf_pf.m})) |=> s_q.thvad == PLEV_PF)
      else $error("low input energy did not drop the threshold to its floor");
endmodule // vaac_core

// *** verilog/vaac_pkg.sv ***
// Operation
// - reset loads every detector state variable with its starting value
// - decision starts only once nine autocorrelations and four reflections arrive
// - decision uses the periodic flag left by the previous frame
// - periodicity update runs after the decision, once both pitch lags arrive
// - filtered energy, threshold and input energy held as exponent plus mantissa
// - value is two to exponent times mantissa over 32768, mantissa at least 16384
// - pseudo-float compare goes by exponent first, then mantissa
// - no pseudo-float add or multiply; energies summed as integers, then normalised
// - energy floor, threshold margin and threshold floor kept as pseudo-float constants
// - filtered energy is r0 times energy plus twice sum of r[i] times acf[i]
// - second-order coefficients come from first two reflections by step-up
// - negative pole imaginary term means not a tone, tone test ends
// - negative pole real term skips the low-frequency check
// - positive real and imaginary: ratio below 0.0973 means not a tone
// - tone when normalised prediction error falls below 0.0447
// - raw decision true when filtered energy strictly exceeds threshold
package vaac_pkg;
   localparam int NACF  = 9;
   localparam int NRC   = 4;
   localparam int LAG_W = 8;

   typedef struct packed {
      logic [15:0] e;
      logic [15:0] m;
   } vaac_pf_type;

   localparam vaac_pf_type PTH_PF     = '{e: 16'h0011, m: 16'h7EF4};
   localparam vaac_pf_type MARGIN_PF  = '{e: 16'h001B, m: 16'h421F};
   localparam vaac_pf_type PLEV_PF    = '{e: 16'h0013, m: 16'h54A3};
   localparam vaac_pf_type THVAD_INIT = '{e: 16'h0014, m: 16'h69CB};

   localparam logic             PTCH_INIT  = 1'b1;
   localparam logic [LAG_W-1:0] LAG0_INIT  = 8'h12;
   localparam logic [LAG_W-1:0] LTHRESH    = 8'h02;
   localparam logic [2:0]       NTHRESH    = 3'h4;
   localparam logic [63:0]      FREQTH_NUM = 64'h3CD;
   localparam logic [63:0]      FREQTH_DEN = 64'h2710;
   localparam logic [15:0]      PREDTH_Q15 = 16'h05B9;
   localparam logic [15:0]      ERR_ONE    = 16'h7FFF;
   localparam logic [16:0]      Q15_ONE    = 17'h08000;
   localparam int               Q15_SH     = 15;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RACC = 3'b001,
      ST_TONE = 3'b010,
      ST_PERR = 3'b011,
      ST_LAGS = 3'b100
   } vaac_state_type;

   typedef struct packed {
      logic [NACF-1:0][31:0] acf;
      logic [NACF-1:0][15:0] coef;
      logic [NRC-1:0][15:0]  rc;
   } vaac_frame_type;

   typedef struct packed {
      logic [LAG_W-1:0] lag1;
      logic [LAG_W-1:0] lag2;
   } vaac_lags_type;

   typedef struct packed {
      vaac_pf_type pvad;
      vaac_pf_type thvad;
      vaac_pf_type input_energy;
      logic        vvad;
      logic        tone;
      logic        ptch_used;
   } vaac_result_type;

   typedef struct packed {
      vaac_state_type       st;
      logic [3:0]           i;
      logic [3:0]           k;
      logic [1:0]           n;
      vaac_frame_type       fr;
      logic signed [39:0]   racc;
      logic signed [71:0]   pacc;
      logic [15:0]          err;
      logic                 ptch;
      logic [2:0]           oldcnt;
      logic [LAG_W-1:0]     lag0;
      vaac_pf_type          thvad;
      vaac_result_type      res;
      logic                 dvalid;
      logic                 started;
   } vaac_regs_type;

   function automatic vaac_pf_type vaac_norm(input logic [47:0] v);
      vaac_pf_type r;
      int          p;
      r = '{e: 16'h0000, m: 16'h0000};
      p = -1;
      for (int b = 0; b < 48; b++)
      begin
         if (v[b])
            p = b;
      end
      if (p >= 0)
      begin
         r.e = 16'(p + 1);
         if (p >= 14)
            r.m = 16'(v >> (p - 14));
         else
            r.m = 16'(v << (14 - p));
      end
      return r;
   endfunction

   function automatic logic vaac_gt(input vaac_pf_type a, input vaac_pf_type b);
      return (a.e > b.e) || ((a.e == b.e) && (a.m > b.m));
   endfunction
endpackage
